/* File: rtl/ibha_port.sv */
`timescale 1ns/1ps
`include "ibha_cfg.svh"
module ibha_port #(
  parameter int DATA_W = 8,
  parameter int SETTLE_CYC = `IBHA_ATN_SETTLE_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [4:0] primary_addr,
  input wire logic [DATA_W-1:0] dio_n_in,
  input wire logic atn_n_in,
  input wire logic ifc_n_in,
  input wire logic ren_n_in,
  input wire logic eoi_n_in,
  input wire logic dav_n_in,
  input wire logic nrfd_n_in,
  input wire logic ndac_n_in,
  output logic [DATA_W-1:0] dio_n_out,
  output logic dio_oe,
  output logic eoi_n_out,
  output logic eoi_oe,
  output logic dav_n_out,
  output logic dav_oe,
  output logic nrfd_n_out,
  output logic nrfd_oe,
  output logic ndac_n_out,
  output logic ndac_oe,
  output logic srq_n_out,
  output logic srq_oe,
  input wire logic service_needed,
  input wire logic [DATA_W-1:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [DATA_W-1:0] rx_data,
  output logic rx_end,
  output logic rx_valid,
  output logic talker,
  output logic listener,
  output logic remote
);
  // ----------------------------------------
  // Input synchronisers.
  // ----------------------------------------
  logic [DATA_W-1:0] dio_s1, dio_s2;
  ibha_pkg::ibha_ctl_s ctl_s1, ctl_s2, ctl_raw;
  assign ctl_raw = '{atn: ~atn_n_in, ifc: ~ifc_n_in, ren: ~ren_n_in, eoi: ~eoi_n_in,
                     dav: ~dav_n_in, nrfd: ~nrfd_n_in, ndac: ~ndac_n_in};
  always_ff @(posedge sys_clk)
  begin
    dio_s1 <= ~dio_n_in;
    dio_s2 <= dio_s1;
    ctl_s1 <= ctl_raw;
    ctl_s2 <= ctl_s1;
  end

  // ----------------------------------------
  // Addressing and mode state.
  // ----------------------------------------
  ibha_pkg::ibha_acc_e acc, next_acc;
  ibha_pkg::ibha_src_e src, next_src;
  logic next_talker, next_listener, next_remote;
  logic [DATA_W-1:0] next_rx_data;
  logic next_rx_end, next_rx_valid;
  logic [7:0] cmd;
  logic [4:0] own_addr;
  logic accept_now;
  assign own_addr = primary_addr & 5'(`IBHA_ADDR_MASK);
  assign cmd = dio_s2[7:0] & `IBHA_CMD_MASK;
  assign accept_now = (acc == ibha_pkg::IBHA_ACC_TAKE);
  always_comb
  begin
    next_talker = talker;
    next_listener = listener;
    next_remote = ctl_s2.ren;
    next_rx_data = rx_data;
    next_rx_end = rx_end;
    next_rx_valid = 1'b0;
    if (ctl_s2.ifc)
    begin
      next_talker = 1'b0;
      next_listener = 1'b0;
    end
    else if (accept_now && ctl_s2.atn)
    begin
      if (cmd == (`IBHA_LISTEN_BASE | {3'h0, own_addr}))
        next_listener = 1'b1;
      else if (cmd == `IBHA_UNLISTEN)
        next_listener = 1'b0;
      else if (cmd == (`IBHA_TALK_BASE | {3'h0, own_addr}))
        next_talker = 1'b1;
      else if (cmd == `IBHA_UNTALK || (cmd & `IBHA_GROUP_MASK) == `IBHA_TALK_BASE)
        next_talker = 1'b0;
      // Secondary bytes fall through untouched.
    end
    else if (accept_now && listener)
    begin
      next_rx_data = dio_s2;
      next_rx_end = ctl_s2.eoi;
      next_rx_valid = 1'b1;
    end
  end

  // ----------------------------------------
  // Acceptor handshake.
  // ----------------------------------------
  logic acc_active;
  logic next_nrfd, next_ndac;
  assign acc_active = (ctl_s2.atn || listener) && !ctl_s2.ifc;
  always_comb
  begin
    next_acc = acc;
    next_nrfd = 1'b0;
    next_ndac = 1'b0;
    case (acc)
      ibha_pkg::IBHA_ACC_READY:
      begin
        next_ndac = acc_active;
        if (acc_active && ctl_s2.dav)
          next_acc = ibha_pkg::IBHA_ACC_TAKE;
      end
      ibha_pkg::IBHA_ACC_TAKE:
      begin
        next_nrfd = 1'b1;
        next_ndac = 1'b1;
        next_acc = ibha_pkg::IBHA_ACC_DONE;
      end
      ibha_pkg::IBHA_ACC_DONE:
      begin
        next_nrfd = 1'b1;
        if (!ctl_s2.dav)
        begin
          next_nrfd = 1'b0;
          next_ndac = acc_active;
          next_acc = ibha_pkg::IBHA_ACC_READY;
        end
      end
      default: next_acc = ibha_pkg::IBHA_ACC_READY;
    endcase
    if (ctl_s2.ifc)
      next_acc = ibha_pkg::IBHA_ACC_READY;
  end

  // ----------------------------------------
  // Source handshake.
  // ----------------------------------------
  logic [$clog2(SETTLE_CYC+1)-1:0] settle_cnt, next_settle_cnt;
  logic [DATA_W-1:0] next_tx_byte;
  logic next_tx_eoi, next_dav, next_drive, next_tx_ready;
  logic src_ok;
  assign src_ok = talker && !ctl_s2.atn && !ctl_s2.ifc;
  always_comb
  begin
    next_src = src;
    next_settle_cnt = settle_cnt;
    next_tx_byte = dio_n_out;
    next_tx_eoi = !eoi_n_out;
    next_dav = 1'b0;
    next_drive = 1'b0;
    next_tx_ready = 1'b0;
    case (src)
      ibha_pkg::IBHA_SRC_IDLE:
      begin
        next_settle_cnt = '0;
        if (src_ok && tx_valid && !tx_ready)
        begin
          next_tx_ready = 1'b1;
          next_tx_byte = ~tx_data;
          next_tx_eoi = tx_last;
          next_drive = 1'b1;
          next_src = ibha_pkg::IBHA_SRC_SETTLE;
        end
      end
      ibha_pkg::IBHA_SRC_SETTLE:
      begin
        next_drive = 1'b1;
        next_settle_cnt = settle_cnt + 1'b1;
        if (settle_cnt >= SETTLE_CYC[$bits(settle_cnt)-1:0])
          next_src = ibha_pkg::IBHA_SRC_WAIT_READY;
      end
      ibha_pkg::IBHA_SRC_WAIT_READY:
      begin
        next_drive = 1'b1;
        if (!ctl_s2.nrfd && ctl_s2.ndac)
        begin
          next_dav = 1'b1;
          next_src = ibha_pkg::IBHA_SRC_VALID;
        end
      end
      ibha_pkg::IBHA_SRC_VALID:
      begin
        next_drive = 1'b1;
        next_dav = 1'b1;
        if (!ctl_s2.ndac)
        begin
          next_dav = 1'b0;
          next_drive = 1'b0;
          next_src = ibha_pkg::IBHA_SRC_RELEASE;
        end
      end
      ibha_pkg::IBHA_SRC_RELEASE:
      begin
        next_tx_eoi = 1'b0;
        if (ctl_s2.ndac || !talker)
          next_src = ibha_pkg::IBHA_SRC_IDLE;
      end
      default: next_src = ibha_pkg::IBHA_SRC_IDLE;
    endcase
    if (!src_ok)
    begin
      next_src = ibha_pkg::IBHA_SRC_IDLE;
      next_dav = 1'b0;
      next_drive = 1'b0;
      next_tx_eoi = 1'b0;
    end
  end

  // ----------------------------------------
  // Registers.
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      acc <= ibha_pkg::IBHA_ACC_READY;
      src <= ibha_pkg::IBHA_SRC_IDLE;
      talker <= 1'b0;
      listener <= 1'b0;
      remote <= 1'b0;
      rx_data <= '0;
      rx_end <= 1'b0;
      rx_valid <= 1'b0;
      settle_cnt <= '0;
      tx_ready <= 1'b0;
      dio_n_out <= '1;
      dio_oe <= 1'b0;
      eoi_n_out <= 1'b1;
      eoi_oe <= 1'b0;
      dav_n_out <= 1'b1;
      dav_oe <= 1'b0;
      nrfd_n_out <= 1'b1;
      nrfd_oe <= 1'b0;
      ndac_n_out <= 1'b1;
      ndac_oe <= 1'b0;
      srq_n_out <= 1'b1;
      srq_oe <= 1'b0;
    end
    else
    begin
      acc <= next_acc;
      src <= next_src;
      talker <= next_talker;
      listener <= next_listener;
      remote <= next_remote;
      rx_data <= next_rx_data;
      rx_end <= next_rx_end;
      rx_valid <= next_rx_valid;
      settle_cnt <= next_settle_cnt;
      tx_ready <= next_tx_ready;
      dio_n_out <= next_tx_byte;
      dio_oe <= next_drive;
      eoi_n_out <= !next_tx_eoi;
      eoi_oe <= next_tx_eoi;
      dav_n_out <= !next_dav;
      dav_oe <= next_dav;
      nrfd_n_out <= !next_nrfd;
      nrfd_oe <= next_nrfd;
      ndac_n_out <= !next_ndac;
      ndac_oe <= next_ndac;
      srq_n_out <= !service_needed;
      srq_oe <= service_needed;
    end
  end
endmodule

/* File: rtl/ibha_cfg.svh */
`ifndef IBHA_CFG_SVH
`define IBHA_CFG_SVH
// ----------------------------------------
// Bus byte codes and timing.
// ----------------------------------------
`define IBHA_LISTEN_BASE 8'h20
`define IBHA_TALK_BASE 8'h40
`define IBHA_SECONDARY_BASE 8'h60
`define IBHA_GROUP_MASK 8'h60
`define IBHA_ADDR_MASK 8'h1f
`define IBHA_UNLISTEN 8'h3f
`define IBHA_UNTALK 8'h5f
`define IBHA_CMD_MASK 8'h7f
`define IBHA_CLK_PERIOD_PS 5000
`define IBHA_ATN_SETTLE_PS 100000
`define IBHA_ATN_SETTLE_CYC ((`IBHA_ATN_SETTLE_PS + `IBHA_CLK_PERIOD_PS - 1) / `IBHA_CLK_PERIOD_PS)
`endif

/* File: rtl/ibha_pkg.sv */
package ibha_pkg;
  // ----------------------------------------
  // Bus line bundles, true-level (1 = asserted).
  // ----------------------------------------
  typedef struct packed {
    logic atn;
    logic ifc;
    logic ren;
    logic eoi;
    logic dav;
    logic nrfd;
    logic ndac;
  } ibha_ctl_s;
  typedef enum {
    IBHA_SRC_IDLE,
    IBHA_SRC_SETTLE,
    IBHA_SRC_WAIT_READY,
    IBHA_SRC_VALID,
    IBHA_SRC_RELEASE
  } ibha_src_e;
  typedef enum {
    IBHA_ACC_READY,
    IBHA_ACC_TAKE,
    IBHA_ACC_DONE
  } ibha_acc_e;
endpackage

/* File: tb/ibha_port_assertions.sv */
`timescale 1ns/1ps
module ibha_chk (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ifc_n_in,
  input wire logic ren_n_in,
  input wire logic nrfd_n_in,
  input wire logic ndac_n_in,
  input wire logic atn_n_in,
  input wire logic service_needed,
  input wire logic dio_oe,
  input wire logic dav_oe,
  input wire logic dav_n_out,
  input wire logic nrfd_oe,
  input wire logic nrfd_n_out,
  input wire logic ndac_oe,
  input wire logic ndac_n_out,
  input wire logic srq_oe,
  input wire logic srq_n_out,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic talker,
  input wire logic listener,
  input wire logic remote
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_srq_raise: assert property (service_needed |=> srq_oe && !srq_n_out) else $error("srq late");
  a_srq_drop: assert property (!service_needed |=> !srq_oe) else $error("srq stuck");
  a_drive_low: assert property ((dav_oe |-> !dav_n_out) and (nrfd_oe |-> !nrfd_n_out)
    and (ndac_oe |-> !ndac_n_out)) else $error("driven high");
  a_ifc_clear: assert property (!ifc_n_in [*4] |=> !talker && !listener) else $error("ifc");
  a_ren_remote: assert property (!ren_n_in [*4] |=> remote) else $error("not remote");
  a_ren_local: assert property (ren_n_in [*4] |=> !remote) else $error("not local");
  a_dav_ready: assert property ($rose(dav_oe) |-> $past(nrfd_n_in, 3) && !$past(ndac_n_in, 3))
    else $error("dav early");
  a_dav_hold: assert property (dav_oe && !ndac_n_in && atn_n_in && ifc_n_in && talker |=> dav_oe)
    else $error("dav dropped");
  a_dav_data: assert property (dav_oe |-> dio_oe) else $error("no data");
  a_tx_drive: assert property (tx_ready |-> dio_oe && talker) else $error("tx");
  a_rx_ack: assert property (rx_valid |-> nrfd_oe && listener ##1 nrfd_oe && !ndac_oe) else $error("rx");
endmodule
bind ibha_port ibha_chk ibha_chk_i (.sys_clk, .reset, .ifc_n_in, .ren_n_in, .nrfd_n_in, .ndac_n_in,
  .atn_n_in, .service_needed, .dio_oe, .dav_oe, .dav_n_out, .nrfd_oe, .nrfd_n_out, .ndac_oe,
  .ndac_n_out, .srq_oe, .srq_n_out, .tx_ready, .rx_valid, .talker, .listener, .remote);

/* File: tb/ibha_ctrl.sv */
`timescale 1ns/1ps
module ibha_ctrl (
  input wire logic sys_clk,
  input wire logic [7:0] dio_n_out,
  input wire logic dio_oe,
  input wire logic eoi_n_out,
  input wire logic eoi_oe,
  input wire logic dav_n_out,
  input wire logic dav_oe,
  input wire logic nrfd_n_out,
  input wire logic nrfd_oe,
  input wire logic ndac_n_out,
  input wire logic ndac_oe,
  output logic [7:0] dio_n,
  output ibha_pkg::ibha_ctl_s pin_n
);
  ibha_pkg::ibha_ctl_s m = '0;
  logic [7:0] d = 8'h00;
  logic got = 1'b0;
  logic [8:0] gb = 9'h000;
  // Released lines rise through the pull-ups; asserted lines win.
  assign dio_n = ~d & (dio_oe ? dio_n_out : 8'hff);
  assign pin_n = ~m & {3'h7, eoi_n_out | ~eoi_oe, dav_n_out | ~dav_oe, nrfd_n_out | ~nrfd_oe, ndac_n_out | ~ndac_oe};
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Source: settle, wait ready, hold valid until accepted.
  task automatic send(logic [7:0] b, logic a, logic e);
    m.atn = a;
    d = b;
    m.eoi = e;
    tick(21);
    while (!(pin_n.nrfd && !pin_n.ndac)) tick(1);
    m.dav = 1'b1;
    while (!pin_n.ndac) tick(1);
    m.dav = 1'b0;
    d = 8'h00;
    m.eoi = 1'b0;
    tick(1);
  endtask
  // Acceptor at its own pace.
  task automatic recv(int slow);
    m.ndac = 1'b1;
    while (pin_n.dav) tick(1);
    tick(slow);
    gb = {!pin_n.eoi, ~dio_n};
    got = 1'b1;
    m.nrfd = 1'b1;
    m.ndac = 1'b0;
    tick(1);
    got = 1'b0;
    while (!pin_n.dav) tick(1);
    m.nrfd = 1'b0;
  endtask
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; $display("BAD %0t mismatch got %h want %h", $time, a, e); end end
module testbench;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic service_needed = 1'b0, tx_last = 1'b0, tx_valid = 1'b0;
  logic [4:0] primary_addr;
  logic [7:0] tx_data = 8'h00, b, dio_n_out, dio_n, rx_data;
  logic dio_oe, eoi_n_out, eoi_oe, dav_n_out, dav_oe, nrfd_n_out, nrfd_oe, ndac_n_out, ndac_oe, srq_n_out, srq_oe;
  logic tx_ready, rx_end, rx_valid, talker, listener, remote;
  logic [8:0] v, want;
  logic [8:0] q[$];
  ibha_pkg::ibha_ctl_s pin_n;
  int fail_count = 0, comparisons = 0, cyc = 0;
  integer seed = 32'h9741d798;
  ibha_port ibha_port_i (.sys_clk, .reset, .primary_addr, .dio_n_in(dio_n), .atn_n_in(pin_n.atn),
    .ifc_n_in(pin_n.ifc), .ren_n_in(pin_n.ren), .eoi_n_in(pin_n.eoi), .dav_n_in(pin_n.dav),
    .nrfd_n_in(pin_n.nrfd), .ndac_n_in(pin_n.ndac), .dio_n_out, .dio_oe, .eoi_n_out, .eoi_oe, .dav_n_out,
    .dav_oe, .nrfd_n_out, .nrfd_oe, .ndac_n_out, .ndac_oe, .srq_n_out, .srq_oe, .service_needed, .tx_data,
    .tx_last, .tx_valid, .tx_ready, .rx_data, .rx_end, .rx_valid, .talker, .listener, .remote);
  ibha_ctrl ibha_ctrl_i (.sys_clk, .dio_n_out, .dio_oe, .eoi_n_out, .eoi_oe, .dav_n_out, .dav_oe,
    .nrfd_n_out, .nrfd_oe, .ndac_n_out, .ndac_oe, .dio_n, .pin_n);
  always #2.5 sys_clk = ~sys_clk;
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tx_byte(logic [7:0] d, logic l);
    tx_data = d;
    tx_last = l;
    tx_valid = 1'b1;
    q.push_back({l, d});
    @(posedge sys_clk);
    while (!tx_ready) @(posedge sys_clk);
    #1;
  endtask
  // ----------------------------------------
  // Result watcher and timeout.
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    cyc++;
    service_needed <= #1 1'($random(seed));
    if (rx_valid || ibha_ctrl_i.got)
    begin
      v = rx_valid ? {rx_end, rx_data} : ibha_ctrl_i.gb;
      if (q.size() == 0)
      begin
        fail_count++;
        $display("BAD %0t unexpected byte", $time);
      end
      else
      begin
        want = q.pop_front();
        `CHK(v, want)
      end
    end
    if (cyc == 20000)
    begin
      fail_count++;
      $display("BAD %0t timeout", $time);
      end_sim();
    end
  end
  initial
  begin
    primary_addr = 5'($unsigned($random(seed)) % 31);
    repeat (8) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    ibha_ctrl_i.m.ren = 1'b1;
    ibha_ctrl_i.send({3'h1, primary_addr}, 1'b1, 1'b0);
    `CHK(listener, 1'b1)
    ibha_ctrl_i.send(8'h60 | 8'($random(seed) & 31), 1'b1, 1'b0);
    `CHK(listener, 1'b1)
    `CHK(remote, 1'b1)
    for (int i = 0; i < 4; i++)
    begin
      b = i == 0 ? 8'h3f : 8'($random(seed));
      q.push_back({i == 3, b});
      ibha_ctrl_i.send(b, 1'b0, i == 3);
    end
    `CHK(listener, 1'b1)
    ibha_ctrl_i.send(8'h3f, 1'b1, 1'b0);
    `CHK(listener, 1'b0)
    $display("test listen done");
    ibha_ctrl_i.send({3'h2, primary_addr}, 1'b1, 1'b0);
    ibha_ctrl_i.m.atn = 1'b0;
    `CHK(talker, 1'b1)
    fork
      for (int i = 0; i < 3; i++) tx_byte(8'($random(seed)), i == 2);
      for (int i = 0; i < 3; i++) ibha_ctrl_i.recv(i * 6);
    join
    tx_valid = 1'b0;
    ibha_ctrl_i.send({3'h2, primary_addr + 5'h01}, 1'b1, 1'b0);
    `CHK(talker, 1'b0)
    $display("test talk done");
    ibha_ctrl_i.send({3'h1, primary_addr}, 1'b1, 1'b0);
    ibha_ctrl_i.m.ifc = 1'b1;
    ibha_ctrl_i.tick(6);
    `CHK(listener, 1'b0)
    ibha_ctrl_i.m = '0;
    ibha_ctrl_i.tick(6);
    `CHK(remote, 1'b0)
    `CHK(q.size(), 0)
    $display("test clear done");
    end_sim();
  end
endmodule
